/* File: rtl/adcs_seq_ctrl.sv */
// sequence control of a successive-approximation converter with register port
// assumes a comparator input from the analog macro on the same clock
`timescale 1ns/1ps
`include "adcs_consts.svh"
module adcs_seq_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cmp_high,
  output logic [7:0] o_rdata,
  output logic [3:0] o_mux_chan,
  output logic o_sample
);
  typedef struct packed {
    adcs_pkg::adcs_state_type st;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] ctl4;
    logic [7:0] ctl5;
    logic done;
    logic [7:0] sar;
    logic [7:0] trial;
    logic [3:0] step_cnt;
    logic [2:0] conv_idx;
    logic [2:0] wr_ptr;
    logic [3:0] mux_chan;
    logic sample;
    logic [7:0] rdata;
  } adcs_regs_type;

  adcs_regs_type q_r;
  adcs_regs_type q_nxt;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic rd_d_r;
  logic [3:0] rd_addr_r;

  // sequence length: one with single-conversion, else eight or four
  function automatic logic [3:0] seq_len(input logic [7:0] c3, input logic [7:0] c5);
    if (c3[`ADCS_CTL3_SINGLE]) begin
      seq_len = 4'd1;
    end else if (c5[`ADCS_CTL5_EIGHT]) begin
      seq_len = 4'd8;
    end else begin
      seq_len = 4'd4;
    end
  endfunction

  // channel of conversion idx, starting at the written channel with wrap
  function automatic logic [3:0] chan_of(input logic [7:0] c5, input logic [2:0] idx);
    logic [2:0] base;
    base = c5[2:0] + idx;
    chan_of = {c5[`ADCS_CTL5_SPECIAL], base};
  endfunction

  // formatted result: signed flips msb, left justify keeps the byte
  function automatic logic [7:0] fmt(input logic [7:0] c2, input logic [7:0] v);
    fmt = c2[`ADCS_CTL2_SIGNED] ? {~v[7], v[6:0]} : v;
  endfunction

  logic wr2, wr3, wr4, wr5, wrt, restart, conv_end;

  always_comb begin
    q_nxt = q_r;
    wr2 = i_wr && (i_addr == `ADCS_OFF_CTL2);
    wr3 = i_wr && (i_addr == `ADCS_OFF_CTL3);
    wr4 = i_wr && (i_addr == `ADCS_OFF_CTL4);
    wr5 = i_wr && (i_addr == `ADCS_OFF_CTL5);
    wrt = i_wr && (i_addr == `ADCS_OFF_TEST) && i_wdata[`ADCS_TEST_RST];
    restart = wr4 || wr5;
    conv_end = 1'b0;
    mem_we = 1'b0;
    mem_waddr = q_r.wr_ptr;
    mem_wdata = fmt(q_r.ctl2, q_r.sar);
    q_nxt.sample = 1'b0;
    if (wr2) begin
      q_nxt.ctl2 = i_wdata;
    end
    if (wr3) begin
      q_nxt.ctl3 = i_wdata;
    end
    if (wr4) begin
      q_nxt.ctl4 = i_wdata;
    end
    if (wr5) begin
      q_nxt.ctl5 = i_wdata;
    end
    case (q_r.st)
      adcs_pkg::ADCS_IDLE: begin
      end
      adcs_pkg::ADCS_CONV: begin
        if (q_r.step_cnt != 4'd0) begin
          q_nxt.step_cnt = q_r.step_cnt - 4'd1;
        end else begin
          q_nxt.step_cnt = 4'(`ADCS_STEP_CYC - 1);
          if (!i_cmp_high) begin
            q_nxt.sar = q_r.sar & ~q_r.trial;
          end
          q_nxt.trial = q_r.trial >> 1;
          if (q_r.trial[0]) begin
            q_nxt.st = adcs_pkg::ADCS_NEXT;
          end else begin
            q_nxt.sar = (i_cmp_high ? q_r.sar : (q_r.sar & ~q_r.trial)) | (q_r.trial >> 1);
          end
        end
      end
      adcs_pkg::ADCS_NEXT: begin
        mem_we = 1'b1;
        // fifo mode keeps filling; otherwise result sits at its conversion slot
        mem_waddr = q_r.ctl3[`ADCS_CTL3_FIFO] ? q_r.wr_ptr : q_r.conv_idx;
        q_nxt.wr_ptr = q_r.wr_ptr + 3'd1;
        q_nxt.sar = 8'h80;
        q_nxt.trial = 8'h80;
        q_nxt.st = adcs_pkg::ADCS_CONV;
        // not equality: a single-conversion bit set mid-sequence must still end it
        if ({1'b0, q_r.conv_idx} + 4'd1 >= seq_len(q_r.ctl3, q_r.ctl5)) begin
          conv_end = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.conv_idx = 3'd0;
          if (!q_r.ctl5[`ADCS_CTL5_SCAN]) begin
            q_nxt.st = adcs_pkg::ADCS_IDLE;
          end
        end else begin
          q_nxt.conv_idx = q_r.conv_idx + 3'd1;
        end
        q_nxt.mux_chan = chan_of(q_r.ctl5, q_nxt.conv_idx);
        q_nxt.sample = q_nxt.st == adcs_pkg::ADCS_CONV;
      end
      default: begin
        q_nxt.st = adcs_pkg::ADCS_IDLE;
      end
    endcase
    if (restart) begin
      // new sequence always starts from the written channel
      q_nxt.st = adcs_pkg::ADCS_CONV;
      q_nxt.conv_idx = 3'd0;
      q_nxt.sar = 8'h80;
      q_nxt.trial = 8'h80;
      q_nxt.step_cnt = 4'(`ADCS_STEP_CYC - 1);
      q_nxt.mux_chan = chan_of(wr5 ? i_wdata : q_r.ctl5, 3'd0);
      q_nxt.sample = 1'b1;
      if (!q_r.ctl3[`ADCS_CTL3_FIFO] || wr5) begin
        q_nxt.wr_ptr = 3'd0;
      end
      if (wr5 && !conv_end) begin
        q_nxt.done = 1'b0;
      end
    end
    if (wrt) begin
      q_nxt.st = adcs_pkg::ADCS_IDLE;
      q_nxt.done = 1'b0;
      q_nxt.sar = 8'h00;
      q_nxt.trial = 8'h00;
      q_nxt.conv_idx = 3'd0;
      q_nxt.wr_ptr = 3'd0;
      q_nxt.sample = 1'b0;
    end
    q_nxt.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ADCS_OFF_CTL2: q_nxt.rdata = q_r.ctl2;
        `ADCS_OFF_CTL3: q_nxt.rdata = q_r.ctl3;
        `ADCS_OFF_CTL4: q_nxt.rdata = q_r.ctl4;
        `ADCS_OFF_CTL5: q_nxt.rdata = q_r.ctl5;
        `ADCS_OFF_STAT: q_nxt.rdata = {q_r.done, 6'h00, q_r.st != adcs_pkg::ADCS_IDLE};
        `ADCS_OFF_TEST: q_nxt.rdata = q_r.sar;
        default: q_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q_r <= '0;
      q_r.st <= adcs_pkg::ADCS_IDLE;
      q_r.ctl2 <= `ADCS_CTL2_RESET;
      q_r.ctl3 <= `ADCS_CTL3_RESET;
      q_r.ctl4 <= `ADCS_CTL4_RESET;
      q_r.ctl5 <= `ADCS_CTL5_RESET;
      rd_d_r <= 1'b0;
      rd_addr_r <= 4'h0;
    end else begin
      q_r <= q_nxt;
      rd_d_r <= i_rd;
      rd_addr_r <= i_addr;
    end
  end

  // result slot read: registered in memory, matched to the one-cycle answer
  adcs_result_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(i_addr[2:0]),
    .o_rdata(mem_rdata)
  );

  // result reads use offsets 8..15 through the slot memory; mux stays registered
  logic [7:0] rdata_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (i_rd && i_addr[3]) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= q_nxt.rdata;
    end
  end
  assign o_rdata = (rd_d_r && rd_addr_r[3]) ? mem_rdata : rdata_r;
  assign o_mux_chan = q_r.mux_chan;
  assign o_sample = q_r.sample;

  a_restart_ctl4: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr4 && !wrt) |=> (q_r.st == adcs_pkg::ADCS_CONV && q_r.conv_idx == 3'd0))
    else $error("control four write did not restart");
  a_cfg_no_abort: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ((wr2 || wr3) && !restart && !wrt && q_r.st == adcs_pkg::ADCS_CONV)
    |=> q_r.st != adcs_pkg::ADCS_IDLE)
    else $error("configuration write aborted sequence");
  a_ctl5_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr5 && !wrt && !conv_end) |=> (!q_r.done && q_r.sample))
    else $error("control five write did not clear and start");
  a_first_chan: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr5 && !wrt) |=> q_r.mux_chan == {$past(i_wdata[4]), $past(i_wdata[2:0])})
    else $error("wrong first channel");
  a_top_bit_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr5 && !wrt && i_wdata[6] && i_wdata[2]) |=> q_r.mux_chan[2])
    else $error("top channel bit masked");
  a_special_route: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (q_r.st != adcs_pkg::ADCS_IDLE && !restart && !wrt)
    |=> q_r.mux_chan[3] == q_r.ctl5[4])
    else $error("special channel not routed");
  a_done_scan: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (conv_end && !wrt) |=> q_r.done)
    else $error("done flag not set at sequence end");
  a_single_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (conv_end && !q_r.ctl5[5] && !restart && !wrt)
    |=> q_r.st == adcs_pkg::ADCS_IDLE)
    else $error("block did not idle after sequence");
  a_test_reset: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wrt |=> (q_r.st == adcs_pkg::ADCS_IDLE && !q_r.done))
    else $error("test reset bit ineffective");
  a_single_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (q_r.ctl3[6] && q_r.st == adcs_pkg::ADCS_NEXT) |-> conv_end)
    else $error("single conversion ran too long");
  a_test_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADCS_OFF_TEST) |=> o_rdata == $past(q_r.sar))
    else $error("test register not returning approximation");
  // the checks below look one edge after the strobe or event they guard
  a_cfg_keep_idx: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ((wr2 || wr3) && !restart && !wrt && q_r.st == adcs_pkg::ADCS_CONV)
    |=> q_r.conv_idx == $past(q_r.conv_idx))
    else $error("configuration write moved the sequence");
  a_scan_goes_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (conv_end && q_r.ctl5[`ADCS_CTL5_SCAN] && !restart && !wrt)
    |=> q_r.st == adcs_pkg::ADCS_CONV)
    else $error("scan did not continue after sequence");
  a_idle_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (q_r.st == adcs_pkg::ADCS_IDLE && !restart)
    |=> !q_r.sample)
    else $error("conversion started while idle");
  a_fifo_ptr_kept: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr4 && !wr5 && !wrt && q_r.ctl3[`ADCS_CTL3_FIFO] && q_r.st != adcs_pkg::ADCS_NEXT)
    |=> q_r.wr_ptr == $past(q_r.wr_ptr))
    else $error("fifo pointer moved on restart");
  a_status_busy: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == `ADCS_OFF_STAT)
    |=> o_rdata[0] == ($past(q_r.st) != adcs_pkg::ADCS_IDLE))
    else $error("busy bit wrong in status");
endmodule

/* File: shared/adcs_consts.svh */
// offsets, field positions, reset values and timing counts of the converter sequencer
// included by the package users; definitions only
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

`define ADCS_OFF_CTL2 4'h2
`define ADCS_OFF_CTL3 4'h3
`define ADCS_OFF_CTL4 4'h4
`define ADCS_OFF_CTL5 4'h5
`define ADCS_OFF_STAT 4'h6
`define ADCS_OFF_TEST 4'h7
`define ADCS_OFF_RSLT 4'h8

// control two
`define ADCS_CTL2_JUSTIFY 7
`define ADCS_CTL2_SIGNED 6
// control three
`define ADCS_CTL3_FIFO 7
`define ADCS_CTL3_SINGLE 6
// control five
`define ADCS_CTL5_EIGHT 6
`define ADCS_CTL5_SCAN 5
`define ADCS_CTL5_SPECIAL 4
// status
`define ADCS_STAT_DONE 7
`define ADCS_STAT_BUSY 0
// test
`define ADCS_TEST_RST 7

`define ADCS_CTL2_RESET 8'h00
`define ADCS_CTL3_RESET 8'h00
`define ADCS_CTL4_RESET 8'h01
`define ADCS_CTL5_RESET 8'h00

// one bit decision per step; wait per step derived from ns and clock
`define ADCS_STEP_NS 64
`define ADCS_CLK_NS 8
`define ADCS_STEP_CYC ((`ADCS_STEP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_SAR_BITS 8

`endif

/* File: shared/adcs_pkg.sv */
// types of the converter sequencer
// no dependencies
package adcs_pkg;
  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b00,
    ADCS_CONV = 2'b01,
    ADCS_NEXT = 2'b10
  } adcs_state_type;
endpackage

/* File: rtl/adcs_result_mem.sv */
// eight-word result store of the converter sequencer
// one write port and one registered read port on the core clock
`timescale 1ns/1ps
module adcs_result_mem (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:7];
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

/* File: tb/adcs_seq_ctrl_bench.sv */
// self-checking bench of the converter sequencer, register port driven directly
// comparator held high, so conversions settle to all ones, except the first fifo sequence, run low to all zeros
`timescale 1ns/1ps
`include "adcs_consts.svh"
module adcs_seq_ctrl_bench;
  typedef struct {logic [3:0] a; logic w; logic [7:0] d; logic [7:0] e;} adcs_row_type;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cmp_high = 1'b1;
  logic [7:0] o_rdata;
  logic [3:0] o_mux_chan;
  logic o_sample;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_smp = 0;
  int base;
  logic [3:0] chans [0:1023];
  logic [7:0] rv;
  adcs_row_type rows [0:9];

  adcs_seq_ctrl u_adcs_seq_ctrl (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cmp_high(i_cmp_high),
    .o_rdata(o_rdata), .o_mux_chan(o_mux_chan), .o_sample(o_sample));

  always #4 i_core_clk = ~i_core_clk;

  // records the channel of every conversion start; also cuts a hang short
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_sample === 1'b1) begin
      chans[n_smp[9:0]] = o_mux_chan;
      n_smp++;
    end
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask

  task automatic wait_smp(input int n);
    int k;
    k = 0;
    while (n_smp - base < n && k < 3000) begin
      @(posedge i_core_clk);
      k++;
    end
    #1 chk(8'(n_smp - base >= n), 8'h01, "conversion start seen");
  endtask

  // waits for the done flag, then lets the block sit to prove it stays idle
  task automatic finish_seq(input int cnt);
    int k;
    k = 0;
    rd(`ADCS_OFF_STAT);
    while (rv[`ADCS_STAT_DONE] !== 1'b1 && k < 1000) begin
      rd(`ADCS_OFF_STAT);
      k++;
    end
    repeat (150) @(posedge i_core_clk);
    rd(`ADCS_OFF_STAT);
    chk(rv & 8'h81, 8'h80, "done set and idle");
    chk(8'(n_smp - base), 8'(cnt), "conversions in sequence");
  endtask

  initial begin
    rows[0] = '{`ADCS_OFF_CTL2, 1'b0, 8'h00, 8'h00};
    rows[1] = '{`ADCS_OFF_CTL3, 1'b0, 8'h00, 8'h00};
    rows[2] = '{`ADCS_OFF_CTL4, 1'b0, 8'h00, 8'h01};
    rows[3] = '{`ADCS_OFF_CTL5, 1'b0, 8'h00, 8'h00};
    rows[4] = '{`ADCS_OFF_STAT, 1'b0, 8'h00, 8'h00};
    rows[5] = '{`ADCS_OFF_CTL2, 1'b1, 8'hc0, 8'hc0};
    rows[6] = '{`ADCS_OFF_CTL3, 1'b1, 8'h80, 8'h80};
    rows[7] = '{`ADCS_OFF_CTL3, 1'b1, 8'h00, 8'h00};
    rows[8] = '{`ADCS_OFF_CTL2, 1'b1, 8'h00, 8'h00};
    rows[9] = '{4'h0, 1'b1, 8'h5a, 8'h00};
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a);
      chk(rv, rows[i].e, "register table");
    end
    $display("register table test ended");

    // eight channels from channel 5; a config write mid-run must not restart it
    base = n_smp;
    wr(`ADCS_OFF_CTL5, 8'h45);
    wait_smp(2);
    repeat (20) @(posedge i_core_clk);
    rd(`ADCS_OFF_TEST);
    chk(8'(rv == 8'h00), 8'h00, "approximation visible");
    wr(`ADCS_OFF_CTL2, 8'h80);
    finish_seq(8);
    chk({4'h0, chans[base]}, 8'h05, "first channel");
    chk({4'h0, chans[base + 3]}, 8'h00, "channel wrap");
    rd(`ADCS_OFF_RSLT);
    chk(rv, 8'hff, "unsigned result");
    $display("eight channel test ended");

    // single conversion of internal reference 3, signed result
    wr(`ADCS_OFF_CTL3, 8'h40);
    wr(`ADCS_OFF_CTL2, 8'h40);
    base = n_smp;
    wr(`ADCS_OFF_CTL5, 8'h13);
    finish_seq(1);
    chk({4'h0, chans[base]}, 8'h0b, "special channel");
    rd(`ADCS_OFF_RSLT);
    chk(rv, 8'h7f, "signed result");
    $display("single conversion test ended");

    // scan restart clears done; done comes back while scanning goes on
    base = n_smp;
    wr(`ADCS_OFF_CTL5, 8'h20);
    rd(`ADCS_OFF_STAT);
    chk(rv & 8'h81, 8'h01, "done cleared, busy");
    wait_smp(3);
    rd(`ADCS_OFF_STAT);
    chk(rv & 8'h81, 8'h81, "done set in scan");
    $display("scan test ended");

    // control four write in mid-conversion starts a new conversion at once
    repeat (20) @(posedge i_core_clk);
    #1 base = n_smp;
    wr(`ADCS_OFF_CTL4, 8'h01);
    #1 chk({7'h00, o_sample}, 8'h01, "prompt restart");
    wait_smp(1);
    chk({4'h0, chans[base]}, 8'h00, "restart channel");
    $display("control four test ended");

    // test register reset bit stops the converter but keeps control registers
    repeat (20) @(posedge i_core_clk);
    wr(`ADCS_OFF_TEST, 8'h80);
    repeat (4) @(posedge i_core_clk);
    #1 base = n_smp;
    repeat (150) @(posedge i_core_clk);
    chk(8'(n_smp - base), 8'h00, "no conversion after reset");
    rd(`ADCS_OFF_STAT);
    chk(rv & 8'h01, 8'h00, "not busy after reset");
    rd(`ADCS_OFF_CTL3);
    chk(rv, 8'h40, "control kept");
    $display("test register reset test ended");

    // fifo: a control four restart keeps filling after the last slot
    i_cmp_high <= 1'b0;
    wr(`ADCS_OFF_CTL2, 8'h00);
    wr(`ADCS_OFF_CTL3, 8'h80);
    base = n_smp;
    wr(`ADCS_OFF_CTL5, 8'h01);
    finish_seq(4);
    i_cmp_high <= 1'b1;
    base = n_smp;
    wr(`ADCS_OFF_CTL4, 8'h01);
    wait_smp(4);
    repeat (80) @(posedge i_core_clk);
    rd(`ADCS_OFF_RSLT + 4'h4);
    chk(rv, 8'hff, "fifo slot after restart");
    rd(`ADCS_OFF_RSLT);
    chk(rv, 8'h00, "fifo slot kept");
    $display("fifo test ended");
    stop_test();
  end
endmodule
